// *** rtl/e1pt_top.sv ***
// E1 test pattern generator, checker, direction swap and bypass control.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "e1pt_consts.svh"

//////////////////////////////////////////////////////////////////////////////
module e1pt_top
  import e1pt_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Bit rate enables
  input  wire logic        line_bit_en,
  input  wire logic        bp_bit_en,
  // Data paths
  input  wire logic        tx_frm_data,
  input  wire logic        rx_frm_data,
  input  wire logic        rx_line_data_in,
  input  wire logic        tx_bp_data_in,
  output logic             tx_line_data,
  output logic             rx_bp_data,
  // Control levels and interrupt
  output logic             tx_framer_skip,
  output logic             rx_framer_skip,
  output logic             defect_detect_on,
  output logic             pattern_lock_flag,
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////////
  // Register bus.

  e1pt_ctl_t       ctl_r;
  logic            swap_r;
  logic            defect_r;
  e1pt_ev_t        irq_stat_r;
  e1pt_ev_t        irq_mask_r;
  e1pt_ev_t        ev;
  logic            inject_pend_r;
  logic      [9:0] idx;
  logic            setup;
  logic            wr_acc;

  function automatic logic is_reg(input logic [9:0] i,
                                  input logic [11:0] r);
    is_reg = ({2'b00, i} == r);
  endfunction : is_reg

  function automatic logic mapped(input logic [9:0] i);
    mapped = is_reg(i, `E1PT_IDX_SWAP) || is_reg(i, `E1PT_IDX_PTCS)
          || is_reg(i, `E1PT_IDX_LOOP_CTL) || is_reg(i, `E1PT_IDX_LOOP_TX)
          || is_reg(i, `E1PT_IDX_LOOP_ACT) || is_reg(i, `E1PT_IDX_LOOP_DEACT)
          || is_reg(i, `E1PT_IDX_DEFECT) || is_reg(i, `E1PT_IDX_IRQ_STAT)
          || is_reg(i, `E1PT_IDX_IRQ_MASK);
  endfunction : mapped

  assign idx     = paddr[11:2];
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite && mapped(idx);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(idx);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_r    <= '0;
      swap_r   <= 1'b0;
      defect_r <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (is_reg(idx, `E1PT_IDX_PTCS))
      begin
        ctl_r.kind    <= pwdata[`E1PT_BIT_KIND];
        ctl_r.inject  <= pwdata[`E1PT_BIT_INJECT];
        ctl_r.chk_en  <= pwdata[`E1PT_BIT_CHK_EN];
        ctl_r.gen_en  <= pwdata[`E1PT_BIT_GEN_EN];
        ctl_r.rx_skip <= pwdata[`E1PT_BIT_RX_SKIP];
        ctl_r.tx_skip <= pwdata[`E1PT_BIT_TX_SKIP];
      end
      else if (is_reg(idx, `E1PT_IDX_SWAP))
        swap_r <= pwdata[`E1PT_BIT_SWAP];
      else if (is_reg(idx, `E1PT_IDX_DEFECT))
        defect_r <= pwdata[`E1PT_BIT_DEFECT_ON];
    end
  end

  // Read data is latched in the setup phase so it stands in the access phase.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      prdata <= '0;
    else if (setup)
    begin
      prdata <= '0;
      if (is_reg(idx, `E1PT_IDX_PTCS))
        prdata[7:0] <= {ctl_r.kind, ctl_r.inject, 1'b0, pattern_lock_flag,
                        ctl_r.chk_en, ctl_r.gen_en, ctl_r.rx_skip,
                        ctl_r.tx_skip};
      else if (is_reg(idx, `E1PT_IDX_SWAP))
        prdata[`E1PT_BIT_SWAP] <= swap_r;
      else if (is_reg(idx, `E1PT_IDX_DEFECT))
        prdata[`E1PT_BIT_DEFECT_ON] <= defect_r;
      else if (is_reg(idx, `E1PT_IDX_IRQ_STAT))
        prdata[1:0] <= irq_stat_r;
      else if (is_reg(idx, `E1PT_IDX_IRQ_MASK))
        prdata[1:0] <= irq_mask_r;
    end
  end

  assign tx_framer_skip   = ctl_r.tx_skip;
  assign rx_framer_skip   = ctl_r.rx_skip;
  assign defect_detect_on = defect_r;

  //////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky events, write one to clear, set wins over clear.

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end
    else
    begin
      if (wr_acc && is_reg(idx, `E1PT_IDX_IRQ_STAT))
        irq_stat_r <= (irq_stat_r & ~pwdata[1:0]) | ev;
      else
        irq_stat_r <= irq_stat_r | ev;
      if (wr_acc && is_reg(idx, `E1PT_IDX_IRQ_MASK))
        irq_mask_r <= pwdata[1:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  //////////////////////////////////////////////////////////////////////////
  // Pattern generator.

  logic        gen_stb;
  logic [19:0] gen_sr_r;
  logic [3:0]  gen_zrun_r;
  logic        gen_raw;
  logic        gen_bit;
  logic        inject_rise;

  // The generator runs at whichever bit rate its output direction uses.
  assign gen_stb = ctl_r.gen_en && (swap_r ? bp_bit_en : line_bit_en);
  assign gen_raw = ctl_r.kind ? (gen_sr_r[19] ^ gen_sr_r[16])
                              : (gen_sr_r[14] ^ gen_sr_r[13]);
  assign gen_bit = (gen_raw
                   | (ctl_r.kind && gen_zrun_r == `E1PT_ZERO_RUN))
                   ^ inject_pend_r;
  assign inject_rise = wr_acc && is_reg(idx, `E1PT_IDX_PTCS)
                    && pwdata[`E1PT_BIT_INJECT] && !ctl_r.inject;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gen_sr_r   <= `E1PT_RST_SEED;
      gen_zrun_r <= '0;
    end
    else if (gen_stb)
    begin
      gen_sr_r <= {gen_sr_r[18:0], gen_raw};
      if (gen_raw)
        gen_zrun_r <= '0;
      else if (gen_zrun_r != `E1PT_ZERO_RUN)
        gen_zrun_r <= gen_zrun_r + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      inject_pend_r <= 1'b0;
    else if (!ctl_r.gen_en)
      inject_pend_r <= 1'b0;
    else if (inject_rise)
      inject_pend_r <= 1'b1;
    else if (gen_stb)
      inject_pend_r <= 1'b0;
  end

  // Outgoing data: pattern replaces framer data in the chosen direction.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_line_data <= 1'b0;
      rx_bp_data   <= 1'b0;
    end
    else
    begin
      if (line_bit_en)
        tx_line_data <= (ctl_r.gen_en && !swap_r) ? gen_bit
                                                  : tx_frm_data;
      if (bp_bit_en)
        rx_bp_data <= (ctl_r.gen_en && swap_r) ? gen_bit
                                               : rx_frm_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pattern checker.

  e1pt_chk_state_t chk_st_r;
  logic            chk_stb;
  logic            chk_in;
  logic            chk_pred;
  logic            chk_match;
  logic     [19:0] chk_sr_r;
  logic      [5:0] match_cnt_r;
  logic      [3:0] miss_cnt_r;

  assign chk_stb   = ctl_r.chk_en && (swap_r ? bp_bit_en : line_bit_en);
  assign chk_in    = swap_r ? tx_bp_data_in : rx_line_data_in;
  assign chk_pred  = ctl_r.kind ? (chk_sr_r[19] ^ chk_sr_r[16])
                                : (chk_sr_r[14] ^ chk_sr_r[13]);
  assign chk_match = (chk_in == chk_pred);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      chk_sr_r <= '0;
    else if (chk_stb)
      chk_sr_r <= {chk_sr_r[18:0], chk_in};
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      chk_st_r    <= E1PT_HUNT;
      match_cnt_r <= '0;
      miss_cnt_r  <= '0;
    end
    else if (!ctl_r.chk_en)
    begin
      chk_st_r    <= E1PT_HUNT;
      match_cnt_r <= '0;
      miss_cnt_r  <= '0;
    end
    else if (chk_stb)
    begin
      case (chk_st_r)
        E1PT_HUNT:
        begin
          miss_cnt_r <= '0;
          if (!chk_match)
            match_cnt_r <= '0;
          else if (match_cnt_r == `E1PT_LOCK_RUN - 6'h1)
          begin
            chk_st_r    <= E1PT_LOCKED;
            match_cnt_r <= '0;
          end
          else
            match_cnt_r <= match_cnt_r + 6'h1;
        end
        E1PT_LOCKED:
        begin
          if (!chk_match)
          begin
            match_cnt_r <= '0;
            if (miss_cnt_r == `E1PT_LOSS_RUN - 4'h1)
            begin
              chk_st_r   <= E1PT_HUNT;
              miss_cnt_r <= '0;
            end
            else
              miss_cnt_r <= miss_cnt_r + 4'h1;
          end
          else if (match_cnt_r == `E1PT_LOCK_RUN - 6'h1)
          begin
            match_cnt_r <= '0;
            miss_cnt_r  <= '0;
          end
          else
            match_cnt_r <= match_cnt_r + 6'h1;
        end
        default:
          chk_st_r <= E1PT_HUNT;
      endcase
    end
  end

  assign pattern_lock_flag = (chk_st_r == E1PT_LOCKED);
  assign ev = '{ev_loss: chk_stb && !chk_match && chk_st_r == E1PT_LOCKED
                         && miss_cnt_r == `E1PT_LOSS_RUN - 4'h1,
                ev_lock: chk_stb && chk_match && chk_st_r == E1PT_HUNT
                         && match_cnt_r == `E1PT_LOCK_RUN - 6'h1};

  //////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_lock_read;
    @(posedge sys_clk) disable iff (!nrst)
    setup && !pwrite && is_reg(idx, `E1PT_IDX_PTCS)
      |=> prdata[`E1PT_BIT_LOCK] == $past(pattern_lock_flag);
  endproperty
  a_lock_read: assert property (p_lock_read)
    else $error("lock bit read back wrong");

  property p_swap_write;
    @(posedge sys_clk) disable iff (!nrst)
    wr_acc && is_reg(idx, `E1PT_IDX_SWAP)
      |=> swap_r == $past(pwdata[`E1PT_BIT_SWAP]);
  endproperty
  a_swap_write: assert property (p_swap_write)
    else $error("swap bit not stored");

  property p_chk_off;
    @(posedge sys_clk) disable iff (!nrst)
    !ctl_r.chk_en |=> !pattern_lock_flag;
  endproperty
  a_chk_off: assert property (p_chk_off)
    else $error("lock held with checker disabled");

  property p_gen_line;
    @(posedge sys_clk) disable iff (!nrst)
    line_bit_en && ctl_r.gen_en && !swap_r
      |=> tx_line_data == $past(gen_bit);
  endproperty
  a_gen_line: assert property (p_gen_line)
    else $error("pattern not sent to line");

  property p_gen_bp;
    @(posedge sys_clk) disable iff (!nrst)
    bp_bit_en && ctl_r.gen_en && swap_r
      |=> rx_bp_data == $past(gen_bit)
          && tx_line_data == ($past(line_bit_en) ? $past(tx_frm_data)
                                                 : $past(tx_line_data));
  endproperty
  a_gen_bp: assert property (p_gen_bp)
    else $error("pattern not sent to backplane");

  property p_skip_write;
    @(posedge sys_clk) disable iff (!nrst)
    wr_acc && is_reg(idx, `E1PT_IDX_PTCS)
      |=> rx_framer_skip == $past(pwdata[`E1PT_BIT_RX_SKIP])
          && tx_framer_skip == $past(pwdata[`E1PT_BIT_TX_SKIP]);
  endproperty
  a_skip_write: assert property (p_skip_write)
    else $error("bypass bits not stored");

  property p_rsvd_read;
    @(posedge sys_clk) disable iff (!nrst)
    setup && (is_reg(idx, `E1PT_IDX_LOOP_CTL)
              || is_reg(idx, `E1PT_IDX_LOOP_DEACT))
      |=> prdata == 32'h0000_0000;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved register not zero");

  property p_inject;
    @(posedge sys_clk) disable iff (!nrst)
    gen_stb && inject_pend_r && !ctl_r.kind && !swap_r
      |=> tx_line_data != $past(gen_raw)
          && (!inject_pend_r || $past(inject_rise));
  endproperty
  a_inject: assert property (p_inject)
    else $error("error inject not single bit");

  property p_lock_run;
    @(posedge sys_clk) disable iff (!nrst)
    $rose(pattern_lock_flag) |-> $past(chk_match)
      && $past(match_cnt_r) == `E1PT_LOCK_RUN - 6'h1;
  endproperty
  a_lock_run: assert property (p_lock_run)
    else $error("lock without full match run");

  property p_irq;
    @(posedge sys_clk) disable iff (!nrst)
    ev.ev_lock && irq_mask_r.ev_lock |=> irq [*2];
  endproperty
  a_irq: assert property (p_irq)
    else $error("lock event did not raise irq");

endmodule : e1pt_top

// *** rtl/e1pt_consts.svh ***
// Register indices, field positions, reset values and checker run lengths.
`ifndef E1PT_CONSTS_SVH
`define E1PT_CONSTS_SVH
`define E1PT_IDX_SWAP      12'h0121
`define E1PT_IDX_PTCS      12'h0124
`define E1PT_IDX_LOOP_CTL   12'h0125
`define E1PT_IDX_LOOP_TX    12'h0126
`define E1PT_IDX_LOOP_ACT   12'h0127
`define E1PT_IDX_LOOP_DEACT 12'h0129
`define E1PT_IDX_DEFECT     12'h0130
`define E1PT_IDX_IRQ_STAT  12'h0140
`define E1PT_IDX_IRQ_MASK  12'h0141
`define E1PT_BIT_KIND      7
`define E1PT_BIT_INJECT    6
`define E1PT_BIT_LOCK      4
`define E1PT_BIT_CHK_EN    3
`define E1PT_BIT_GEN_EN    2
`define E1PT_BIT_RX_SKIP   1
`define E1PT_BIT_TX_SKIP   0
`define E1PT_BIT_SWAP      3
`define E1PT_BIT_DEFECT_ON 7
`define E1PT_BIT_EV_LOCK   0
`define E1PT_BIT_EV_LOSS   1
`define E1PT_RST_BYTE      8'h00
`define E1PT_RST_SEED      20'h0_0001
`define E1PT_LOCK_RUN      6'h20
`define E1PT_LOSS_RUN      4'h8
`define E1PT_ZERO_RUN      4'he
`endif

// *** rtl/e1pt_pkg.sv ***
// Types shared by the E1 pattern test and bypass control block.
package e1pt_pkg;
  typedef struct packed {
    logic kind;
    logic inject;
    logic chk_en;
    logic gen_en;
    logic rx_skip;
    logic tx_skip;
  } e1pt_ctl_t;

  typedef struct packed {
    logic ev_loss;
    logic ev_lock;
  } e1pt_ev_t;

  typedef enum logic [1:0] {
    E1PT_HUNT   = 2'b01,
    E1PT_LOCKED = 2'b10
  } e1pt_chk_state_t;
endpackage : e1pt_pkg

// *** sim/e1pt_far_model.sv ***
// Far side model: line interface and backplane with bit enables and loops.
`timescale 1ns/1ps

module e1pt_far_model
(
  // Clock, reset and fault control
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic corrupt,
  // Data coming from the block
  input  wire logic tx_line_data,
  input  wire logic rx_bp_data,
  // Data and enables toward the block
  output logic      line_bit_en,
  output logic      bp_bit_en,
  output logic      rx_line_data_in,
  output logic      tx_bp_data_in,
  output logic      tx_frm_data,
  output logic      rx_frm_data
);
  logic [1:0] cnt_r;

  //////////////////////////////////////////////////////////////////////////
  // One line bit and one backplane bit every four clocks, out of phase.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= 2'h0;
    else
      cnt_r <= cnt_r + 2'h1;
  end
  assign line_bit_en = (cnt_r == 2'h0);
  assign bp_bit_en   = (cnt_r == 2'h2);

  //////////////////////////////////////////////////////////////////////////
  // Framer data alternates so that it never looks like a valid pattern.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_frm_data <= 1'b0;
      rx_frm_data <= 1'b0;
    end
    else
    begin
      if (line_bit_en)
        tx_frm_data <= ~tx_frm_data;
      if (bp_bit_en)
        rx_frm_data <= ~rx_frm_data;
    end
  end

  // Both far ends loop back; corrupt inverts every returned bit.
  assign rx_line_data_in = tx_line_data ^ corrupt;
  assign tx_bp_data_in   = rx_bp_data ^ corrupt;
endmodule : e1pt_far_model

// *** sim/tb.sv ***
// Self-checking testbench of the E1 pattern test and bypass control block.
`timescale 1ns/1ps
`include "e1pt_consts.svh"

module tb;
  import e1pt_pkg::*;
  logic        sys_clk, nrst, psel, penable, pwrite, corrupt, en_d, mon_sel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, line_bit_en, bp_bit_en, tx_frm_data, err;
  logic        rx_frm_data, rx_line_data_in, tx_bp_data_in, tx_line_data;
  logic        rx_bp_data, tx_framer_skip, rx_framer_skip, defect_detect_on;
  logic        pattern_lock_flag, irq, mon_bit;
  logic [14:0] hist;
  int          checks, bad_count, mon_viol, v0;

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  e1pt_top e1pt_top_inst (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_bit_en(line_bit_en), .bp_bit_en(bp_bit_en),
    .tx_frm_data(tx_frm_data), .rx_frm_data(rx_frm_data),
    .rx_line_data_in(rx_line_data_in), .tx_bp_data_in(tx_bp_data_in),
    .tx_line_data(tx_line_data), .rx_bp_data(rx_bp_data),
    .tx_framer_skip(tx_framer_skip), .rx_framer_skip(rx_framer_skip),
    .defect_detect_on(defect_detect_on),
    .pattern_lock_flag(pattern_lock_flag), .irq(irq));

  e1pt_far_model e1pt_far_model_inst (.sys_clk(sys_clk), .nrst(nrst),
    .corrupt(corrupt), .tx_line_data(tx_line_data), .rx_bp_data(rx_bp_data),
    .line_bit_en(line_bit_en), .bp_bit_en(bp_bit_en),
    .rx_line_data_in(rx_line_data_in), .tx_bp_data_in(tx_bp_data_in),
    .tx_frm_data(tx_frm_data), .rx_frm_data(rx_frm_data));

  ////////////////////////////////////////////////////////////////////////////
  // Counts generated bits that break the x^15 + x^14 + 1 recurrence.
  assign mon_bit = mon_sel ? rx_bp_data : tx_line_data;
  always @(posedge sys_clk)
  begin
    en_d <= mon_sel ? bp_bit_en : line_bit_en;
    if (en_d)
    begin
      hist <= {hist[13:0], mon_bit};
      if (mon_bit !== (hist[13] ^ hist[14]))
        mon_viol <= mon_viol + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx[9:0], 2'b00};
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      chk("pready", 32'h0000_0000, 32'h0000_0001);
  endtask : apb

  task automatic rdchk(input string what, input logic [11:0] idx,
                       input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(what, rd, exp);
  endtask : rdchk

  task automatic wait_lock(input logic want);
    int n;
    n = 0;
    while (pattern_lock_flag !== want && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    #1;
  endtask : wait_lock

  // Framer data must pass one edge after a bit enable when not generating.
  task automatic t_pass(input logic sel, input string what);
    logic f;
    do
    begin
      @(posedge sys_clk);
      #1;
    end
    while ((sel ? bp_bit_en : line_bit_en) !== 1'b1);
    f = sel ? rx_frm_data : tx_frm_data;
    @(posedge sys_clk);
    #1;
    chk(what, sel ? rx_bp_data : tx_line_data, f);
  endtask : t_pass

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk("ptcs reset", `E1PT_IDX_PTCS, 32'h0000_0000);
    rdchk("swap reset", `E1PT_IDX_SWAP, 32'h0000_0000);
    chk("lock reset", pattern_lock_flag, 1'b0);
    chk("skip reset", {tx_framer_skip, rx_framer_skip}, 2'b00);
  endtask : t_reset

  task automatic t_regs;
    logic [11:0] lc [4];
    lc = '{`E1PT_IDX_LOOP_CTL, `E1PT_IDX_LOOP_TX, `E1PT_IDX_LOOP_ACT,
           `E1PT_IDX_LOOP_DEACT};
    apb(1'b1, `E1PT_IDX_PTCS, 32'h0000_0011);
    #1;
    chk("tx skip", {tx_framer_skip, rx_framer_skip}, 2'b10);
    rdchk("lock ro", `E1PT_IDX_PTCS, 32'h0000_0001);
    apb(1'b1, `E1PT_IDX_PTCS, 32'h0000_0002);
    #1;
    chk("rx skip", {tx_framer_skip, rx_framer_skip}, 2'b01);
    apb(1'b1, `E1PT_IDX_PTCS, 32'h0000_0000);
    #1;
    chk("skip off", {tx_framer_skip, rx_framer_skip}, 2'b00);
    t_pass(1'b0, "tx pass");
    apb(1'b1, `E1PT_IDX_DEFECT, 32'h0000_0080);
    #1;
    chk("defect on", defect_detect_on, 1'b1);
    foreach (lc[i])
    begin
      apb(1'b1, lc[i], 32'h0000_00ff);
      rdchk("loop code", lc[i], 32'h0000_0000);
      chk("loop code err", err, 1'b0);
    end
    apb(1'b0, 12'h3ff, 32'h0000_0000);
    chk("unmapped err", err, 1'b1);
  endtask : t_regs

  task automatic t_lock(input logic sw, input logic kind);
    apb(1'b1, `E1PT_IDX_PTCS, 32'h0000_0000);
    apb(1'b1, `E1PT_IDX_SWAP, {28'h0, sw, 3'h0});
    apb(1'b1, `E1PT_IDX_IRQ_MASK, 32'h0000_0003);
    apb(1'b1, `E1PT_IDX_IRQ_STAT, 32'h0000_0003);
    mon_sel <= sw;
    apb(1'b1, `E1PT_IDX_PTCS, {24'h0, kind, 7'h0c});
    wait_lock(1'b1);
    chk("lock", pattern_lock_flag, 1'b1);
    rdchk("lock bit", `E1PT_IDX_PTCS, {24'h0, kind, 7'h1c});
    rdchk("lock event", `E1PT_IDX_IRQ_STAT, 32'h0000_0001);
    chk("irq lock", irq, 1'b1);
    v0 = mon_viol;
    repeat (160) @(posedge sys_clk);
    chk("pattern", mon_viol != v0, kind);
    t_pass(~sw, "other dir pass");
  endtask : t_lock

  task automatic t_inject;
    v0 = mon_viol;
    apb(1'b1, `E1PT_IDX_PTCS, 32'h0000_004c);
    repeat (160) @(posedge sys_clk);
    #1;
    chk("inject flips", mon_viol - v0, 32'd3);
    chk("lock kept", pattern_lock_flag, 1'b1);
    apb(1'b1, `E1PT_IDX_PTCS, 32'h0000_000c);
  endtask : t_inject

  task automatic t_loss;
    apb(1'b1, `E1PT_IDX_IRQ_MASK, 32'h0000_0000);
    apb(1'b1, `E1PT_IDX_IRQ_STAT, 32'h0000_0003);
    corrupt <= 1'b1;
    wait_lock(1'b0);
    chk("lock lost", pattern_lock_flag, 1'b0);
    rdchk("loss event", `E1PT_IDX_IRQ_STAT, 32'h0000_0002);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, `E1PT_IDX_IRQ_MASK, 32'h0000_0002);
    #1;
    chk("irq unmasked", irq, 1'b1);
    apb(1'b1, `E1PT_IDX_IRQ_STAT, 32'h0000_0002);
    #1;
    chk("irq cleared", irq, 1'b0);
    corrupt <= 1'b0;
  endtask : t_loss

  task automatic t_chkoff;
    apb(1'b1, `E1PT_IDX_PTCS, 32'h0000_0004);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("chk off", pattern_lock_flag, 1'b0);
    apb(1'b1, `E1PT_IDX_PTCS, 32'h0000_0000);
    t_pass(1'b1, "bp pass");
  endtask : t_chkoff

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    corrupt = 1'b0;
    mon_sel = 1'b0;
    en_d = 1'b0;
    hist = 15'h0000;
    mon_viol = 0;
    checks = 0;
    bad_count = 0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset;
    t_regs;
    t_lock(1'b0, 1'b0);
    t_inject;
    t_loss;
    t_lock(1'b0, 1'b1);
    t_lock(1'b1, 1'b0);
    t_chkoff;
    final_report;
  end

  initial
  begin
    #400_000;
    bad_count++;
    final_report;
  end
endmodule : tb
